// [rtl/ame_pkg.sv]
// Purpose: Shared codes, lengths and framing helpers for the auth exchange
// Assumes: One octet per link beat, first octet of a message is its type
// Notes:   Value elements carry at most 8 content octets (64-bit values)
package ame_pkg;

  localparam logic [7:0] MT_AUTH_REQ  = 8'h40;
  localparam logic [7:0] MT_AUTH_REP  = 8'h41;
  localparam logic [7:0] EI_SEL       = 8'h0a;
  localparam logic [7:0] EI_CHAL      = 8'h0c;
  localparam logic [7:0] EI_ANS       = 8'h0d;
  localparam logic [7:0] EI_SEED      = 8'h0e;
  localparam int         LEN_SEL      = 5;
  localparam int         LEN_CHAL_STD = 10;
  localparam int         LEN_ANS_STD  = 6;
  localparam int         HDR_LEN      = 2;
  // Algorithm code carried in the selector; value is arbitrary
  localparam logic [7:0] ALG_STD_ID   = 8'h01;
  localparam int         MAX_MSG      = 26;
  localparam int         LEN_E        = 128;
  localparam int         RES_BITS     = 32;
  localparam int         KEY_BITS     = 64;

  typedef enum logic [1:0] {RX_TYPE, RX_EI, RX_LEN, RX_BODY} ame_rxph_t;

  typedef struct packed {
    ame_rxph_t   ph;
    logic [7:0]  mtype;
    logic [7:0]  ei;
    logic [7:0]  left;
    logic [63:0] acc;
    logic [63:0] chal;
    logic [63:0] seed;
    logic [31:0] ans;
    logic [7:0]  alg;
    logic        has_sel;
    logic        has_chal;
    logic        has_seed;
    logic        has_ans;
    logic        err;
  } ame_rx_t;

  // One octet of the element walker; unknown elements are skipped by length
  function automatic ame_rx_t ame_rx_step(input ame_rx_t s, input logic [7:0] d,
                                          input logic last, input int ch_len,
                                          input int ans_len);
    ame_rx_t     r;
    logic [63:0] a;
    r = s;
    a = {s.acc[55:0], d};
    case (s.ph)
      RX_TYPE: begin
        r       = '0;
        r.mtype = d;
        r.ph    = RX_EI;
      end
      RX_EI: begin
        r.ei = d;
        r.ph = RX_LEN;
      end
      RX_LEN: begin
        r.left = d;
        r.acc  = '0;
        r.ph   = (d == 8'h00) ? RX_EI : RX_BODY;
        if ((s.ei == EI_CHAL || s.ei == EI_SEED) && d != 8'(ch_len - HDR_LEN))
          r.err = 1'b1;
        if (s.ei == EI_ANS && d != 8'(ans_len - HDR_LEN))
          r.err = 1'b1;
        if (s.ei == EI_SEL && d != 8'(LEN_SEL - HDR_LEN))
          r.err = 1'b1;
      end
      default: begin
        r.acc  = a; // First content octet ends up most significant
        r.left = s.left - 8'h01;
        if (s.left == 8'h01) begin
          r.ph = RX_EI;
          if (s.ei == EI_CHAL) begin
            r.chal     = a;
            r.has_chal = 1'b1;
          end else if (s.ei == EI_SEED) begin
            r.seed     = a;
            r.has_seed = 1'b1;
          end else if (s.ei == EI_ANS) begin
            r.ans     = a[31:0];
            r.has_ans = 1'b1;
          end else if (s.ei == EI_SEL) begin
            r.alg     = a[23:16];
            r.has_sel = 1'b1;
          end // Other elements fall through unused
        end
      end
    endcase
    if (last) begin
      if (r.ph != RX_EI)
        r.err = 1'b1; // Message cut inside an element
      r.ph = RX_TYPE;
    end
    return r;
  endfunction

  // Appends EI, length octet and big-endian content at octet position cnt
  function automatic logic [8*MAX_MSG-1:0] ame_app(input logic [8*MAX_MSG-1:0] msg,
                                                   input int cnt, input logic [7:0] ei,
                                                   input int total, input logic [63:0] val);
    logic [8*MAX_MSG-1:0] m;
    logic [7:0]           b;
    int                   n;
    m = msg;
    n = total - HDR_LEN;
    for (int i = 0; i < MAX_MSG; i++) begin
      b = 8'h00;
      if (i < total && cnt + i < MAX_MSG) begin
        if (i == 0)
          b = ei;
        else if (i == 1)
          b = 8'(n);
        else
          b = val[8*(n-1-(i-2)) +: 8];
        m[8*(MAX_MSG-1-(cnt+i)) +: 8] = b;
      end
    end
    return m;
  endfunction

  function automatic logic [RES_BITS-1:0] ame_res(input logic [LEN_E-1:0] e);
    logic [RES_BITS-1:0] r;
    for (int i = 0; i < RES_BITS; i++)
      r[i] = e[i % LEN_E];
    return r;
  endfunction

  function automatic logic [KEY_BITS-1:0] ame_key(input logic [LEN_E-1:0] e);
    logic [KEY_BITS-1:0] k;
    for (int i = 0; i < KEY_BITS; i++)
      k[i] = e[(i + RES_BITS) % LEN_E];
    return k;
  endfunction

endpackage

// [rtl/ame_link_if.sv]
// Purpose: Octet link between the fixed end and the portable end
// Assumes: Both ends on the same clock, no back-pressure
// Notes:   last marks the final octet of a message
`timescale 1ns/1ps
interface ame_link_if;
  logic       f2p_valid;
  logic [7:0] f2p_data;
  logic       f2p_last;
  logic       p2f_valid;
  logic [7:0] p2f_data;
  logic       p2f_last;

  modport fixed_end (output f2p_valid, output f2p_data, output f2p_last,
                     input p2f_valid, input p2f_data, input p2f_last);
  modport portable_end (input f2p_valid, input f2p_data, input f2p_last,
                        output p2f_valid, output p2f_data, output p2f_last);
endinterface

// [rtl/ame_portable_end.sv]
// Purpose: Portable end of the authentication message exchange
// Assumes: User logic supplies the algorithm output and expected answers
// Notes:   One exchange at a time; a request seen while busy starts no new exchange
`timescale 1ns/1ps
module ame_portable_end import ame_pkg::*; #(
  parameter int         CH_BYTES  = LEN_CHAL_STD,
  parameter int         ANS_BYTES = LEN_ANS_STD,
  parameter logic [7:0] ALG_ID    = ALG_STD_ID
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  ame_link_if.portable_end         link,
  input  wire logic                auth_fs_start,
  input  wire logic [63:0]         pchal_in,
  input  wire logic                key_alloc_in,
  input  wire logic [31:0]         kalloc_ans_in,
  input  wire logic                pans_valid,
  input  wire logic [LEN_E-1:0]    alg_out_in,
  input  wire logic                xfans_valid,
  input  wire logic [31:0]         xfans_in,
  output logic                     busy,
  output logic                     req_valid,
  output logic                     reply_valid,
  output logic [63:0]              rx_seed,
  output logic [63:0]              rx_fchal,
  output logic [31:0]              rx_fans,
  output logic                     fs_ok,
  output logic                     call_drop,
  output logic                     proto_err,
  output logic [KEY_BITS-1:0]      key_out
);

  typedef enum {P_IDLE, P_WAIT_REPLY, P_WAIT_ANS, P_WAIT_XFANS} ame_pstate_t;

  ame_pstate_t          state_ff;
  ame_pstate_t          nxt_state;
  ame_rx_t              rx_ff;
  ame_rx_t              nxt_rx;
  logic [8*MAX_MSG-1:0] tx_msg_ff;
  logic [8*MAX_MSG-1:0] nxt_msg;
  logic [7:0]           tx_left_ff;
  logic [7:0]           nxt_len;
  logic                 load;
  logic                 rx_done;
  logic                 is_req;
  logic                 is_rep;
  logic                 req_ok;
  logic                 rep_ok;
  logic                 req_valid_ff;
  logic                 reply_valid_ff;
  logic [63:0]          seed_ff;
  logic [63:0]          fchal_ff;
  logic [31:0]          fans_ff;
  logic                 ok_ff;
  logic                 drop_ff;
  logic                 err_ff;
  logic [KEY_BITS-1:0]  key_ff;

  always_comb nxt_rx = ame_rx_step(rx_ff, link.f2p_data, link.f2p_last, CH_BYTES, ANS_BYTES);

  assign rx_done = link.f2p_valid && link.f2p_last;
  assign is_req  = nxt_rx.mtype == MT_AUTH_REQ;
  assign is_rep  = nxt_rx.mtype == MT_AUTH_REP;
  assign req_ok  = !nxt_rx.err && nxt_rx.has_sel && nxt_rx.alg == ALG_ID &&
                   nxt_rx.has_seed && nxt_rx.has_chal;
  assign rep_ok  = !nxt_rx.err && nxt_rx.has_seed && nxt_rx.has_ans;

  always_ff @(posedge clk) begin
    if (sys_rst)
      rx_ff <= '0;
    else if (link.f2p_valid)
      rx_ff <= nxt_rx;
  end

  always_comb begin
    nxt_state = state_ff;
    load      = 1'b0;
    nxt_msg   = {MT_AUTH_REQ, {(8*(MAX_MSG-1)){1'b0}}};
    nxt_len   = 8'h00;
    case (state_ff)
      P_IDLE: begin
        if (rx_done && is_req && req_ok) begin
          nxt_state = P_WAIT_ANS;
        end else if (auth_fs_start && tx_left_ff == 8'h00) begin
          load    = 1'b1; // Fresh challenge toward the fixed end
          nxt_msg = ame_app(nxt_msg, 1, EI_SEL, LEN_SEL, 64'({ALG_ID, 16'h0000}));
          nxt_msg = ame_app(nxt_msg, 1 + LEN_SEL, EI_CHAL, CH_BYTES, pchal_in);
          nxt_len = 8'(1 + LEN_SEL + CH_BYTES);
          if (key_alloc_in) begin
            nxt_msg = ame_app(nxt_msg, 1 + LEN_SEL + CH_BYTES, EI_ANS, ANS_BYTES,
                              64'(kalloc_ans_in));
            nxt_len = 8'(1 + LEN_SEL + CH_BYTES + ANS_BYTES);
          end
          nxt_state = P_WAIT_REPLY;
        end
      end
      P_WAIT_REPLY: begin
        if (rx_done && is_rep)
          nxt_state = rep_ok ? P_WAIT_XFANS : P_IDLE;
      end
      P_WAIT_ANS: begin
        if (pans_valid && tx_left_ff == 8'h00) begin
          load      = 1'b1;
          nxt_msg   = {MT_AUTH_REP, {(8*(MAX_MSG-1)){1'b0}}};
          nxt_msg   = ame_app(nxt_msg, 1, EI_ANS, ANS_BYTES,
                              64'(ame_res(alg_out_in)));
          nxt_len   = 8'(1 + ANS_BYTES);
          nxt_state = P_IDLE;
        end
      end
      default: begin
        if (xfans_valid)
          nxt_state = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      state_ff <= P_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_msg_ff  <= '0;
      tx_left_ff <= 8'h00;
    end else if (load) begin
      tx_msg_ff  <= nxt_msg;
      tx_left_ff <= nxt_len;
    end else if (tx_left_ff != 8'h00) begin
      tx_msg_ff  <= tx_msg_ff << 8;
      tx_left_ff <= tx_left_ff - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_valid_ff   <= 1'b0;
      reply_valid_ff <= 1'b0;
      seed_ff        <= '0;
      fchal_ff       <= '0;
      fans_ff        <= '0;
    end else begin
      req_valid_ff   <= state_ff == P_IDLE && nxt_state == P_WAIT_ANS;
      reply_valid_ff <= state_ff == P_WAIT_REPLY && nxt_state == P_WAIT_XFANS;
      if (rx_done && (is_req || is_rep)) begin
        seed_ff  <= nxt_rx.seed;
        fchal_ff <= nxt_rx.chal;
        fans_ff  <= nxt_rx.ans;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ok_ff   <= 1'b0;
      drop_ff <= 1'b0;
      err_ff  <= 1'b0;
      key_ff  <= '0;
    end else begin
      ok_ff   <= state_ff == P_WAIT_XFANS && xfans_valid && xfans_in == fans_ff;
      drop_ff <= state_ff == P_WAIT_XFANS && xfans_valid && xfans_in != fans_ff;
      err_ff  <= rx_done && ((is_req && !req_ok) || (is_rep && !rep_ok));
      if (state_ff == P_WAIT_ANS && load)
        key_ff <= ame_key(alg_out_in);
    end
  end

  assign busy           = state_ff != P_IDLE;
  assign req_valid      = req_valid_ff;
  assign reply_valid    = reply_valid_ff;
  assign rx_seed        = seed_ff;
  assign rx_fchal       = fchal_ff;
  assign rx_fans        = fans_ff;
  assign fs_ok          = ok_ff;
  assign call_drop      = drop_ff;
  assign proto_err      = err_ff;
  assign key_out        = key_ff;
  assign link.p2f_valid = tx_left_ff != 8'h00;
  assign link.p2f_last  = tx_left_ff == 8'h01;
  assign link.p2f_data  = tx_msg_ff[8*MAX_MSG-1 -: 8];

endmodule

// [rtl/ame_fixed_end.sv]
// Purpose: Fixed end of the authentication message exchange
// Assumes: User logic supplies seed, challenge and algorithm output
// Notes:   Parser walks elements octet by octet; no received message is buffered
//
// What this block does
// - Request type 0x40, reply type 0x41
// - Type top bit zero; else not ours
// - Portable request: selector plus portable challenge
// - Fixed request: selector, seed, fixed challenge
// - Portable answer only in key allocation requests
// - Element codes: challenge 0x0c, answer 0x0d, seed 0x0e
// - Selector code 0x0a, five bytes total
// - Standard lengths: challenge/seed 10, answer 6
// - Element lengths set per algorithm by parameter
// - Value MSB in top bit of octet 3
// - Value LSB in bottom bit of last octet
// - Unknown elements skipped by length
// - Fixed end gathers values before requesting
// - Portable end replies with its answer
// - Answer mismatch at fixed end drops call
// - Portable end challenges with fresh value
// - Fixed reply carries seed and fixed answer
// - Portable end compares; mismatch drops call
// - Answer leads algorithm output, cipher key follows
`timescale 1ns/1ps
module ame_fixed_end import ame_pkg::*; #(
  parameter int         CH_BYTES  = LEN_CHAL_STD,
  parameter int         ANS_BYTES = LEN_ANS_STD,
  parameter logic [7:0] ALG_ID    = ALG_STD_ID
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  ame_link_if.fixed_end            link,
  input  wire logic                auth_ps_start,
  input  wire logic [63:0]         seed_in,
  input  wire logic [63:0]         fchal_in,
  input  wire logic [LEN_E-1:0]    alg_out_in,
  input  wire logic                fans_valid,
  input  wire logic [63:0]         fans_seed_in,
  input  wire logic [31:0]         fans_in,
  output logic                     busy,
  output logic                     pchal_valid,
  output logic [63:0]              pchal_out,
  output logic                     key_alloc,
  output logic [31:0]              kalloc_ans,
  output logic                     ps_ok,
  output logic                     call_drop,
  output logic                     proto_err,
  output logic [KEY_BITS-1:0]      key_out
);

  typedef enum {F_IDLE, F_WAIT_REPLY, F_WAIT_ANS} ame_fstate_t;

  ame_fstate_t          state_ff;
  ame_fstate_t          nxt_state;
  ame_rx_t              rx_ff;
  ame_rx_t              nxt_rx;
  logic [8*MAX_MSG-1:0] tx_msg_ff;
  logic [8*MAX_MSG-1:0] nxt_msg;
  logic [7:0]           tx_left_ff;
  logic [7:0]           nxt_len;
  logic                 load;
  logic                 start_ok;
  logic                 rx_done;
  logic                 is_req;
  logic                 is_rep;
  logic                 req_ok;
  logic                 rep_ok;
  logic [RES_BITS-1:0]  xres_ff;
  logic [KEY_BITS-1:0]  key_ff;
  logic                 pchal_valid_ff;
  logic [63:0]          pchal_ff;
  logic                 key_alloc_ff;
  logic [31:0]          kalloc_ans_ff;
  logic                 ok_ff;
  logic                 drop_ff;
  logic                 err_ff;

  // Element walker runs on every valid octet from the portable end
  always_comb nxt_rx = ame_rx_step(rx_ff, link.p2f_data, link.p2f_last, CH_BYTES, ANS_BYTES);

  assign rx_done = link.p2f_valid && link.p2f_last;
  // Any type with the top bit set is some other message and is ignored
  assign is_req  = nxt_rx.mtype == MT_AUTH_REQ;
  assign is_rep  = nxt_rx.mtype == MT_AUTH_REP;
  assign req_ok  = !nxt_rx.err && nxt_rx.has_sel && nxt_rx.alg == ALG_ID &&
                   nxt_rx.has_chal;
  assign rep_ok  = !nxt_rx.err && nxt_rx.has_ans;

  always_ff @(posedge clk) begin
    if (sys_rst)
      rx_ff <= '0;
    else if (link.p2f_valid)
      rx_ff <= nxt_rx;
  end

  // An incoming request wins over a local start in the same cycle
  always_comb begin
    nxt_state = state_ff;
    load      = 1'b0;
    start_ok  = 1'b0;
    nxt_msg   = {MT_AUTH_REQ, {(8*(MAX_MSG-1)){1'b0}}};
    nxt_len   = 8'h00;
    case (state_ff)
      F_IDLE: begin
        if (rx_done && is_req && req_ok) begin
          nxt_state = F_WAIT_ANS;
        end else if (auth_ps_start && tx_left_ff == 8'h00) begin
          // Seed, challenge and expected answer arrive with the start
          start_ok  = 1'b1;
          load      = 1'b1;
          nxt_msg   = ame_app(nxt_msg, 1, EI_SEL, LEN_SEL,
                              64'({ALG_ID, 16'h0000}));
          nxt_msg   = ame_app(nxt_msg, 1 + LEN_SEL, EI_SEED, CH_BYTES,
                              seed_in);
          nxt_msg   = ame_app(nxt_msg, 1 + LEN_SEL + CH_BYTES, EI_CHAL, CH_BYTES,
                              fchal_in);
          nxt_len   = 8'(1 + LEN_SEL + 2 * CH_BYTES);
          nxt_state = F_WAIT_REPLY;
        end
      end
      F_WAIT_REPLY: begin
        if (rx_done && is_rep)
          nxt_state = F_IDLE;
      end
      default: begin
        if (fans_valid && tx_left_ff == 8'h00) begin
          load      = 1'b1;
          nxt_msg   = {MT_AUTH_REP, {(8*(MAX_MSG-1)){1'b0}}};
          nxt_msg   = ame_app(nxt_msg, 1, EI_SEED, CH_BYTES, fans_seed_in);
          nxt_msg   = ame_app(nxt_msg, 1 + CH_BYTES, EI_ANS, ANS_BYTES,
                              64'(fans_in));
          nxt_len   = 8'(1 + CH_BYTES + ANS_BYTES);
          nxt_state = F_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      state_ff <= F_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Message is held whole and shifted out, so data leaves straight from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_msg_ff  <= '0;
      tx_left_ff <= 8'h00;
    end else if (load) begin
      tx_msg_ff  <= nxt_msg;
      tx_left_ff <= nxt_len;
    end else if (tx_left_ff != 8'h00) begin
      tx_msg_ff  <= tx_msg_ff << 8;
      tx_left_ff <= tx_left_ff - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xres_ff <= '0;
      key_ff  <= '0;
    end else if (start_ok) begin
      xres_ff <= ame_res(alg_out_in);
      key_ff  <= ame_key(alg_out_in);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pchal_valid_ff <= 1'b0;
      pchal_ff       <= '0;
      key_alloc_ff   <= 1'b0;
      kalloc_ans_ff  <= '0;
    end else begin
      pchal_valid_ff <= state_ff == F_IDLE && nxt_state == F_WAIT_ANS;
      if (state_ff == F_IDLE && nxt_state == F_WAIT_ANS) begin
        pchal_ff      <= nxt_rx.chal;
        key_alloc_ff  <= nxt_rx.has_ans;
        kalloc_ans_ff <= nxt_rx.ans;
      end
    end
  end

  // A malformed reply ends the exchange without any comparison
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ok_ff   <= 1'b0;
      drop_ff <= 1'b0;
      err_ff  <= 1'b0;
    end else begin
      ok_ff   <= state_ff == F_WAIT_REPLY && rx_done && is_rep && rep_ok &&
                 nxt_rx.ans == xres_ff;
      drop_ff <= state_ff == F_WAIT_REPLY && rx_done && is_rep && rep_ok &&
                 nxt_rx.ans != xres_ff;
      err_ff  <= rx_done && ((is_req && !req_ok) || (is_rep && !rep_ok));
    end
  end

  assign busy           = state_ff != F_IDLE;
  assign pchal_valid    = pchal_valid_ff;
  assign pchal_out      = pchal_ff;
  assign key_alloc      = key_alloc_ff;
  assign kalloc_ans     = kalloc_ans_ff;
  assign ps_ok          = ok_ff;
  assign call_drop      = drop_ff;
  assign proto_err      = err_ff;
  assign key_out        = key_ff;
  assign link.f2p_valid = tx_left_ff != 8'h00;
  assign link.f2p_last  = tx_left_ff == 8'h01;
  assign link.f2p_data  = tx_msg_ff[8*MAX_MSG-1 -: 8];

endmodule

// [verif/ame_monitor.sv]
// Purpose: Wire checks on the octet link between the fixed and portable ends
// Assumes: Both ends stream each message without gaps
// Notes:   The first-octet flags mark where a type octet is due
`timescale 1ns/1ps
module ame_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       f2p_valid,
  input wire logic [7:0] f2p_data,
  input wire logic       f2p_last,
  input wire logic       p2f_valid,
  input wire logic [7:0] p2f_data,
  input wire logic       p2f_last
);
  logic f_first_ff;
  logic p_first_ff;
  wire  f_ty = f2p_valid && f_first_ff;
  wire  p_ty = p2f_valid && p_first_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) f_first_ff <= 1'b1;
    else if (f2p_valid) f_first_ff <= f2p_last;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) p_first_ff <= 1'b1;
    else if (p2f_valid) p_first_ff <= p2f_last;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_f_last_valid: assert property (f2p_last |-> f2p_valid)
    else $error("f2p last without valid");
  a_p_last_valid: assert property (p2f_last |-> p2f_valid)
    else $error("p2f last without valid");
  a_f_type_code: assert property (f_ty |-> f2p_data inside {8'h40, 8'h41})
    else $error("bad f2p type octet");
  a_p_type_code: assert property (p_ty |-> p2f_data inside {8'h40, 8'h41})
    else $error("bad p2f type octet");
  a_f_req_order: assert property (f_ty && f2p_data == 8'h40 |=> f2p_data == 8'h0a
    ##1 f2p_data == 8'h03 ##4 f2p_data == 8'h0e ##1 f2p_data == 8'h08
    ##9 f2p_data == 8'h0c ##1 f2p_data == 8'h08 ##8 f2p_last)
    else $error("fixed request layout wrong");
  a_p_req_order: assert property (p_ty && p2f_data == 8'h40 |=> p2f_data == 8'h0a
    ##1 p2f_data == 8'h03 ##4 p2f_data == 8'h0c ##1 p2f_data == 8'h08)
    else $error("portable request layout wrong");
  a_f_reply_order: assert property (f_ty && f2p_data == 8'h41 |=> f2p_data == 8'h0e
    ##1 f2p_data == 8'h08 ##9 f2p_data == 8'h0d ##1 f2p_data == 8'h04 ##4 f2p_last)
    else $error("fixed reply layout wrong");
  a_p_reply_order: assert property (p_ty && p2f_data == 8'h41 |=> p2f_data == 8'h0d
    ##1 p2f_data == 8'h04 ##4 p2f_last)
    else $error("portable reply layout wrong");
endmodule

// [verif/auth_message_exchange_test.sv]
// Purpose: Self-checking bench for both ends of the auth exchange
// Assumes: Standard element lengths; the two ends share one link
// Notes:   A second fixed end faces a bench driver sending one well-formed frame and three faulty or foreign ones
`timescale 1ns/1ps
module auth_message_exchange_test import ame_pkg::*; ;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             auth_ps_start = 1'b0, fans_valid = 1'b0, auth_fs_start = 1'b0;
  logic             key_alloc_in = 1'b0, pans_valid = 1'b0, xfans_valid = 1'b0;
  logic [63:0]      seed_in = '0, fchal_in = '0, fans_seed_in = '0, pchal_in = '0;
  logic [31:0]      fans_in = '0, kalloc_ans_in = '0, xfans_in = '0;
  logic [LEN_E-1:0] f_alg = '0, p_alg = '0;
  logic [131:0]     exp_q[$];
  logic [7:0]       m[$];
  int               mismatches = 0, samples_checked = 0, cycles = 0, seed = 32'habf9;

  ame_link_if link ();
  ame_link_if link2 ();
  ame_fixed_end i_ame_fixed_end (.clk(clk), .sys_rst(sys_rst), .link(link),
    .auth_ps_start(auth_ps_start), .seed_in(seed_in), .fchal_in(fchal_in), .alg_out_in(f_alg),
    .fans_valid(fans_valid), .fans_seed_in(fans_seed_in), .fans_in(fans_in), .busy(),
    .pchal_valid(), .pchal_out(), .key_alloc(), .kalloc_ans(), .ps_ok(), .call_drop(),
    .proto_err(), .key_out());
  // Only the parser matters here, so its local start stays off
  ame_fixed_end i_ame_fixed_end_b (.clk(clk), .sys_rst(sys_rst), .link(link2),
    .auth_ps_start(1'b0), .seed_in(seed_in), .fchal_in(fchal_in), .alg_out_in(f_alg),
    .fans_valid(fans_valid), .fans_seed_in(fans_seed_in), .fans_in(fans_in), .busy(),
    .pchal_valid(), .pchal_out(), .key_alloc(), .kalloc_ans(), .ps_ok(), .call_drop(),
    .proto_err(), .key_out());
  ame_portable_end i_ame_portable_end (.clk(clk), .sys_rst(sys_rst), .link(link),
    .auth_fs_start(auth_fs_start), .pchal_in(pchal_in), .key_alloc_in(key_alloc_in),
    .kalloc_ans_in(kalloc_ans_in), .pans_valid(pans_valid), .alg_out_in(p_alg),
    .xfans_valid(xfans_valid), .xfans_in(xfans_in), .busy(), .req_valid(), .reply_valid(),
    .rx_seed(), .rx_fchal(), .rx_fans(), .fs_ok(), .call_drop(), .proto_err(), .key_out());
  ame_monitor i_ame_monitor (.clk(clk), .sys_rst(sys_rst), .f2p_valid(link.f2p_valid),
    .f2p_data(link.f2p_data), .f2p_last(link.f2p_last), .p2f_valid(link.p2f_valid),
    .p2f_data(link.p2f_data), .p2f_last(link.p2f_last));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [131:0] seen, input logic [131:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // An event with no note pending is always a mismatch
  task automatic got(input logic [3:0] k, input logic [127:0] v);
    chk("event", {k, v}, (exp_q.size() != 0) ? exp_q.pop_front() : '1);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic settle;
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(negedge clk);
    chk("queue", 132'(exp_q.size()), 132'h0);
    repeat (2) @(negedge clk);
  endtask
  // Released line shows the inverse so a stale octet cannot pass
  task automatic send;
    foreach (m[k]) begin
      @(negedge clk);
      link2.p2f_valid = 1'b1;
      link2.p2f_data = m[k];
      link2.p2f_last = (k == m.size() - 1);
    end
    @(negedge clk);
    link2.p2f_valid = 1'b0;
    link2.p2f_last = 1'b0;
    link2.p2f_data = ~link2.p2f_data;
  endtask
  function automatic logic [63:0] key_of(input logic [LEN_E-1:0] e);
    for (int i = 0; i < 64; i++) key_of[i] = e[(i + 32) % LEN_E];
  endfunction

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  always @(posedge clk) begin
    if (!sys_rst) begin
      if (i_ame_portable_end.req_valid)
        got(4'h1, {i_ame_portable_end.rx_seed, i_ame_portable_end.rx_fchal});
      if (i_ame_fixed_end.ps_ok)
        got(4'h2, {i_ame_fixed_end.key_out, i_ame_portable_end.key_out});
      if (i_ame_fixed_end.call_drop) got(4'h3, 128'h0);
      if (i_ame_fixed_end.pchal_valid) got(4'h4, {i_ame_fixed_end.kalloc_ans
        & {32{i_ame_fixed_end.key_alloc}}, 31'h0, i_ame_fixed_end.key_alloc, i_ame_fixed_end.pchal_out});
      if (i_ame_portable_end.reply_valid)
        got(4'h5, {i_ame_portable_end.rx_seed, 32'h0, i_ame_portable_end.rx_fans});
      if (i_ame_portable_end.fs_ok) got(4'h6, 128'h0);
      if (i_ame_portable_end.call_drop) got(4'h7, 128'h0);
      if (i_ame_fixed_end_b.proto_err) got(4'h8, 128'h0);
      if (i_ame_fixed_end_b.pchal_valid) got(4'h9, {64'h0, i_ame_fixed_end_b.pchal_out});
      if (i_ame_fixed_end.proto_err || i_ame_portable_end.proto_err) got(4'ha, 128'h0);
    end
  end

  initial begin
    link2.p2f_valid = 1'b0;
    link2.p2f_data = 8'h00;
    link2.p2f_last = 1'b0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 2; i++) begin
      seed_in = {$random(seed), $random(seed)};
      fchal_in = {$random(seed), $random(seed)};
      f_alg = {$random(seed), $random(seed), $random(seed), $random(seed)};
      p_alg = f_alg ^ 128'(i == 1);
      exp_q.push_back({4'h1, seed_in, fchal_in});
      pulse(auth_ps_start);
      chk("busy", 132'(i_ame_fixed_end.busy), 132'h1);
      settle();
      exp_q.push_back((i != 0) ? {4'h3, 128'h0} : {4'h2, key_of(f_alg), key_of(f_alg)});
      pulse(pans_valid);
      settle();
      $display("fixed side test %0d done", i);
    end
    for (int i = 0; i < 3; i++) begin
      pchal_in = {$random(seed), $random(seed)};
      kalloc_ans_in = $random(seed);
      key_alloc_in = (i == 2);
      exp_q.push_back({4'h4, kalloc_ans_in & {32{key_alloc_in}}, 31'h0, key_alloc_in, pchal_in});
      pulse(auth_fs_start);
      chk("busy", 132'(i_ame_portable_end.busy), 132'h1);
      settle();
      fans_seed_in = {$random(seed), $random(seed)};
      fans_in = $random(seed);
      exp_q.push_back({4'h5, fans_seed_in, 32'h0, fans_in});
      pulse(fans_valid);
      settle();
      xfans_in = fans_in ^ {i == 1, 31'h0};
      exp_q.push_back({(i == 1) ? 4'h7 : 4'h6, 128'h0});
      pulse(xfans_valid);
      settle();
      $display("portable side test %0d done", i);
    end
    for (int j = 0; j < 4; j++) begin
      m = {(j == 0) ? 8'hc0 : 8'h40, 8'h22, 8'h02, 8'h5a, 8'ha5, 8'h0a, 8'h03, ALG_STD_ID,
           8'h00, 8'h00};
      if (j != 3) begin
        m.push_back(8'h0c);
        m.push_back((j == 2) ? 8'h07 : 8'h08);
        for (int k = 7; k >= ((j == 2) ? 1 : 0); k--) m.push_back(pchal_in[8*k +: 8]);
      end
      if (j == 1) exp_q.push_back({4'h9, 64'h0, pchal_in});
      if (j > 1) exp_q.push_back({4'h8, 128'h0});
      send();
      settle();
      $display("fault frame test %0d done", j);
    end
    summarize();
  end
endmodule
